// *** include/pld_pkg.sv ***
package pld_pkg;

    localparam int CELL_COUNT     = 10;
    localparam int FLOPS_PER_CELL = 2;
    localparam int FLOP_COUNT     = CELL_COUNT * FLOPS_PER_CELL;
    localparam int ADDR_W         = 8;
    localparam int DATA_W         = 32;

    // Byte offsets of the configuration and status registers.
    localparam logic [ADDR_W-1:0] ADDR_TYPE_CFG   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CLKSEL_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SECURITY   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_REG_STATE  = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PIN_INPUT  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_OE_STATE   = 8'h14;

    localparam logic [FLOP_COUNT-1:0] TYPE_CFG_RST   = 20'h00000;
    localparam logic [FLOP_COUNT-1:0] CLKSEL_CFG_RST = 20'h00000;
    localparam logic [FLOP_COUNT-1:0] FUSES_HIDDEN   = 20'hfffff;
    localparam int                    SECURE_BIT     = 0;
    localparam logic [DATA_W-1:0]     DATA_ZERO      = 32'h00000000;

    // Product-term inputs of the flip-flops, one bit per flip-flop.
    typedef struct packed {
        logic [FLOP_COUNT-1:0] sum_term;
        logic [FLOP_COUNT-1:0] rst_term;
        logic [FLOP_COUNT-1:0] clk_term;
    } flop_terms_s;

    // Pin side of the I/O cells.
    typedef struct packed {
        logic [CELL_COUNT-1:0] pin_o;
        logic [CELL_COUNT-1:0] pin_oe;
    } pin_drive_s;

endpackage : pld_pkg

// *** verilog/pld_macrocell_array.sv ***
// Functional notes
// R01: Each flip-flop selectable as D or T.
// R02: Clock per flop: product term or pin.
// R03: Two flip-flops per cell, twenty total.
// R04: Own sum, reset, clock term each flop.
// R05: Each I/O pin has dedicated input path.
// R06: All twenty registers feed back to array.
// R07: Per-pin output enable from own term.
// R08: One synchronous preset shared by all flops.
// R09: Driver forces register clocks high during preset.
// R10: Per-flop asynchronous reset from reset term.
// R11: Reset clears master and slave stages.
// R12: Secured device reads all fuses programmed.
// R13: Program security fuse last; immediate effect.
// R14: T-type toggles on edge when sum true.
// R15: Async reset beats preset and data.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

module pld_macrocell_array #(
    parameter int CELLS          = pld_pkg::CELL_COUNT,
    parameter int FLOPS_PER_CELL = pld_pkg::FLOPS_PER_CELL
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pld_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [pld_pkg::DATA_W-1:0]    pwdata,
    output logic      [pld_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire pld_pkg::flop_terms_s          terms,
    input  wire logic                          clk_pin,
    input  wire logic                          sync_preset,
    input  wire logic [pld_pkg::CELL_COUNT-1:0] oe_term,
    input  wire logic [pld_pkg::CELL_COUNT-1:0] pin_i,
    output pld_pkg::pin_drive_s                pin_drive,
    output logic      [pld_pkg::CELL_COUNT-1:0] pin_to_array,
    output logic      [pld_pkg::FLOP_COUNT-1:0] feedback
);
    import pld_pkg::*;

    localparam int FLOPS = CELLS * FLOPS_PER_CELL;

    // The struct carriers fix the widths, so other sizes cannot be served.
    // R03: twenty flops
    if (FLOPS_PER_CELL != 2 || CELLS != CELL_COUNT || FLOPS != FLOP_COUNT) begin : g_size_check
        $error("Array size must be ten cells of two flip-flops.");
    end

    logic [FLOP_COUNT-1:0] type_cfg_r;
    logic [FLOP_COUNT-1:0] clksel_cfg_r;
    logic                  secure_r;
    logic [FLOP_COUNT-1:0] state;
    logic [CELL_COUNT-1:0] pin_in_r;
    logic [CELL_COUNT-1:0] oe_r;
    logic [DATA_W-1:0]     prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;
    logic                  wr_access;

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        reg_mapped = (addr == ADDR_TYPE_CFG)  || (addr == ADDR_CLKSEL_CFG) ||
                     (addr == ADDR_SECURITY)  || (addr == ADDR_REG_STATE)  ||
                     (addr == ADDR_PIN_INPUT) || (addr == ADDR_OE_STATE);
    endfunction : reg_mapped

    function automatic logic [DATA_W-1:0] widen_flops(input logic [FLOP_COUNT-1:0] v);
        widen_flops = {{(DATA_W-FLOP_COUNT){1'b0}}, v};
    endfunction : widen_flops

    function automatic logic [DATA_W-1:0] widen_cells(input logic [CELL_COUNT-1:0] v);
        widen_cells = {{(DATA_W-CELL_COUNT){1'b0}}, v};
    endfunction : widen_cells

    // A write takes effect only at the edge that completes the access phase.
    assign wr_access = psel && penable && pready_r && pwrite && reg_mapped(paddr);

    // Configuration fuses stay writable after securing, as an erase would allow.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            type_cfg_r   <= TYPE_CFG_RST;
            clksel_cfg_r <= CLKSEL_CFG_RST;
        end else if (wr_access) begin
            if (paddr == ADDR_TYPE_CFG) begin
                type_cfg_r <= pwdata[FLOP_COUNT-1:0];
            end
            if (paddr == ADDR_CLKSEL_CFG) begin
                clksel_cfg_r <= pwdata[FLOP_COUNT-1:0];
            end
        end
    end

    // The security fuse only sets; only a full reset, standing for an erase, clears it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secure_r <= 1'b0;
        end else if (wr_access && paddr == ADDR_SECURITY && pwdata[SECURE_BIT]) begin
            secure_r <= 1'b1;
        end
    end

    // Read data is formed in the setup cycle so the access phase needs no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= DATA_ZERO;
        end else if (psel && !penable) begin
            pready_r  <= 1'b1;
            pslverr_r <= !reg_mapped(paddr);
            prdata_r  <= DATA_ZERO;
            if (!pwrite) begin
                unique case (paddr)
                    // R12: hide fuses
                    ADDR_TYPE_CFG:   prdata_r <= widen_flops(secure_r ? FUSES_HIDDEN : type_cfg_r);
                    ADDR_CLKSEL_CFG: prdata_r <= widen_flops(secure_r ? FUSES_HIDDEN
                                                                      : clksel_cfg_r);
                    ADDR_SECURITY:   prdata_r <= widen_flops({{(FLOP_COUNT-1){1'b0}}, secure_r});
                    ADDR_REG_STATE:  prdata_r <= widen_flops(state);
                    ADDR_PIN_INPUT:  prdata_r <= widen_cells(pin_in_r);
                    ADDR_OE_STATE:   prdata_r <= widen_cells(oe_r);
                    default:         prdata_r <= DATA_ZERO;
                endcase
            end
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= DATA_ZERO;
        end
    end

    // R05: dedicated input path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_in_r <= '0;
        end else begin
            pin_in_r <= pin_i;
        end
    end

    // R07: per-pin enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_r <= '0;
        end else begin
            oe_r <= oe_term;
        end
    end

    // R03: two flops per cell
    for (genvar i = 0; i < FLOP_COUNT; i++) begin : g_flop
        logic clk_sel;
        logic clk_prev_r;
        logic clk_rise;
        logic d_in;
        logic master_r;
        logic slave_r;

        // R02: clock source select
        assign clk_sel  = clksel_cfg_r[i] ? clk_pin : terms.clk_term[i];
        assign clk_rise = clk_sel && !clk_prev_r;

        // R01: D or T
        // R14: toggle on sum
        // R04: own sum term
        assign d_in = type_cfg_r[i] ? (terms.sum_term[i] ^ slave_r) : terms.sum_term[i];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                clk_prev_r <= 1'b0;
            end else begin
                clk_prev_r <= clk_sel;
            end
        end

        // The master follows while the selected clock is low and closes when it rises.
        // R10: per-flop async reset
        // R11: clear master stage
        // R15: reset has priority
        always_ff @(posedge pclk or negedge presetn or posedge terms.rst_term[i]) begin
            if (!presetn || terms.rst_term[i]) begin
                master_r <= 1'b0;
            end else if (!clk_sel) begin
                master_r <= d_in;
            end
        end

        // Preset acts only with a clock edge; the driver keeps the clocks moving high.
        // R11: clear slave stage
        // R15: reset beats preset
        // R08: shared synchronous preset
        // R09: needs clock edge
        always_ff @(posedge pclk or negedge presetn or posedge terms.rst_term[i]) begin
            if (!presetn || terms.rst_term[i]) begin
                slave_r <= 1'b0;
            end else if (clk_rise) begin
                slave_r <= sync_preset ? 1'b1 : master_r;
            end
        end

        assign state[i] = slave_r;
    end

    // R06: all flops fed back
    assign feedback = state;

    // The first flip-flop of each cell drives the pin; the second stays buried.
    for (genvar c = 0; c < CELL_COUNT; c++) begin : g_pin
        assign pin_drive.pin_o[c] = state[c*FLOPS_PER_CELL];
    end
    assign pin_drive.pin_oe = oe_r;
    assign pin_to_array     = pin_in_r;
    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;

endmodule : pld_macrocell_array

// *** verif/pld_assertions.sv ***
`timescale 1ns/1ps
module pld_assertions
    import pld_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire pld_pkg::flop_terms_s terms,
    input wire logic                 clk_pin,
    input wire logic                 sync_preset,
    input wire logic [9:0]           oe_term,
    input wire logic [9:0]           pin_i,
    input wire pld_pkg::pin_drive_s  pin_drive,
    input wire logic [9:0]           pin_to_array,
    input wire logic [19:0]          feedback
);
    logic [19:0] term_q_r;
    logic        pin_q_r;
    logic [19:0] rise_any;
    logic [9:0]  even_fb;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_q_r <= 20'h00000;
            pin_q_r  <= 1'b0;
        end else begin
            term_q_r <= terms.clk_term;
            pin_q_r  <= clk_pin;
        end
    end
    // Either clock source may be selected, so any rise may move a flop.
    always_comb begin
        rise_any = (terms.clk_term & ~term_q_r) | {20{clk_pin & ~pin_q_r}};
        for (int c = 0; c < 10; c++) begin
            even_fb[c] = feedback[2*c];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence ready_pulse;
        pready ##1 !pready;
    endsequence
    chk_ready_pulse: assert property (apb_setup |=> ready_pulse)
        else $error("pready not a single cycle after setup");
    chk_err_unmapped: assert property (psel && !penable && paddr > 8'h14 |=> pslverr && pready)
        else $error("unmapped access without error");
    chk_idle_quiet: assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
        else $error("read data or error outside answer cycle");
    chk_reset_clears: assert property ((terms.rst_term & feedback) == 20'h00000)
        else $error("flop set while its reset term is high");
    chk_pin_map: assert property (pin_drive.pin_o == even_fb)
        else $error("pin output differs from even flop");
    chk_oe_delay: assert property ($past(presetn) |-> pin_drive.pin_oe == $past(oe_term))
        else $error("output enable does not follow its term");
    chk_input_path: assert property ($past(presetn) |-> pin_to_array == $past(pin_i))
        else $error("pin input path wrong");
    chk_hold_state: assert property ($past(presetn) |-> ((feedback ^ $past(feedback))
        & ~$past(rise_any) & ~terms.rst_term & ~$past(terms.rst_term)) == 20'h00000)
        else $error("flop changed without a clock rise");
    chk_preset_all: assert property (sync_preset && clk_pin && !pin_q_r
        && (&(terms.clk_term & ~term_q_r)) && !(|terms.rst_term)
        |=> (|terms.rst_term) || (&feedback))
        else $error("preset did not set every flop");
endmodule : pld_assertions
bind pld_macrocell_array pld_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr,
    .prdata, .pready, .pslverr, .terms, .clk_pin, .sync_preset, .oe_term, .pin_i,
    .pin_drive, .pin_to_array, .feedback);

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import pld_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, err, clk_pin = 0, sync_preset = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0]  oe_term = 10'h000, pin_i = 10'h000, pin_to_array;
    logic [19:0] feedback;
    flop_terms_s terms = '0;
    pin_drive_s  pin_drive;
    int          err_total = 0, samples_checked = 0;
    always #20 pclk = ~pclk;
    pld_macrocell_array DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .terms, .clk_pin, .sync_preset, .oe_term, .pin_i,
        .pin_drive, .pin_to_array, .feedback);
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            results();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask : apb
    // Clock low one cycle, high two, then low again so the next rise is clean.
    task pulse(input logic [19:0] m, input logic p);
        @(posedge pclk);
        terms.clk_term <= m; clk_pin <= p;
        repeat (2) @(posedge pclk);
        terms.clk_term <= 20'h00000; clk_pin <= 0;
        repeat (2) @(posedge pclk);
    endtask : pulse
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_TYPE_CFG, 0);     check("type reset", rd, 0);
        apb(0, 8'h18, 0);             check("unmapped err", {31'h0, err}, 1);
        check("unmapped data", rd, 0);
        apb(1, ADDR_REG_STATE, 32'hfffff); apb(0, ADDR_REG_STATE, 0);
        check("state ro", rd, 0);
        $display("register test done");
        @(posedge pclk) terms.sum_term <= 20'h00005;
        pulse(20'h00001, 0);          check("d capture", feedback, 20'h00001);
        check("pin out", pin_drive.pin_o, 10'h001);
        @(posedge pclk) terms.sum_term <= 20'h00000;
        pulse(20'h00001, 0);          check("d clear", feedback, 0);
        $display("d flop test done");
        apb(1, ADDR_TYPE_CFG, 32'h2); apb(1, ADDR_CLKSEL_CFG, 32'h2);
        @(posedge pclk) terms.sum_term <= 20'h00002;
        pulse(20'h00000, 1);          check("t toggle up", feedback, 20'h00002);
        apb(0, ADDR_REG_STATE, 0);    check("state read", rd, 32'h2);
        pulse(20'h00000, 1);          check("t toggle down", feedback, 0);
        pulse(20'h00002, 0);          check("term ignored", feedback, 0);
        @(posedge pclk) terms.sum_term <= 20'h00000;
        pulse(20'h00000, 1);          check("t hold", feedback, 0);
        $display("t flop test done");
        // clocks driven high while preset is applied
        @(posedge pclk) begin
            sync_preset <= 1;
            terms.rst_term <= 20'h00008;
        end
        pulse(20'hfffff, 1);          check("preset", feedback, 20'hffff7);
        check("preset pins", pin_drive.pin_o, 10'h3ff);
        // A second preset with no reset term lets the checker see every flop set.
        @(posedge pclk) terms.rst_term <= 20'h00000;
        pulse(20'hfffff, 1);          check("preset all", feedback, 20'hfffff);
        @(posedge pclk) begin
            sync_preset <= 0;
            terms.rst_term <= 20'h00000;
        end
        $display("preset test done");
        @(posedge pclk) begin
            oe_term <= 10'h155;
            pin_i <= 10'h2aa;
        end
        repeat (2) @(posedge pclk);
        check("pin path", pin_to_array, 10'h2aa);
        check("oe path", pin_drive.pin_oe, 10'h155);
        apb(0, ADDR_PIN_INPUT, 0);    check("pin reg", rd, 32'h2aa);
        apb(0, ADDR_OE_STATE, 0);     check("oe reg", rd, 32'h155);
        $display("pin test done");
        apb(1, ADDR_SECURITY, 1);
        apb(0, ADDR_TYPE_CFG, 0);     check("hidden type", rd, 32'hfffff);
        apb(0, ADDR_CLKSEL_CFG, 0);   check("hidden clk", rd, 32'hfffff);
        $display("security test done");
        results();
    end
endmodule : testbench
